// ---- verilog/bus_state_params.svh ----
// Constants for the bus remote/local state logic: offsets, fields, resets.
// Assumes inclusion by the design module and the bench only.
`ifndef BUS_STATE_PARAMS_SVH
`define BUS_STATE_PARAMS_SVH
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_STB       12'h008
`define OFS_ADDR      12'h00c
`define OFS_EVENT     12'h010
`define CTRL_BUSTRIG  0
`define CTRL_SRQEN    1
`define ADDR_DEFAULT  5'h10
`define ADDR_MAX      5'h1e
`define STB_RQS       6
`define CMD_GTL       7'h01
`define CMD_SDC       7'h04
`define CMD_GET       7'h08
`define CMD_LLO       7'h11
`define CMD_DCL       7'h14
`define CMD_SPE       7'h18
`define CMD_SPD       7'h19
`define GRP_LISTEN    2'b01
`define GRP_TALK      2'b10
`define UNL_LOW       5'h1f
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// ---- verilog/bus_state_pkg.sv ----
// Types shared by the bus remote/local state logic.
// Assumes the params header is on the include path.
`default_nettype none
package bus_state_pkg;
  // Front panel lamps carried together
  typedef struct packed {
    logic remote;
    logic talk;
    logic listen;
    logic service;
  } lamps_t;
  // Bus byte as sampled: attention flag plus data
  typedef struct packed {
    logic       atn;
    logic [7:0] data;
  } busbyte_t;
endpackage
`default_nettype wire

// ---- verilog/bus_remote_local.sv ----
// Device-side remote/local, lockout, talker and listener state logic.
// Assumes bus pins arrive asynchronous to ref_clk; a byte handshake
// elsewhere gives byteStrobe per accepted byte; AXI4-Lite master on ref_clk.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bus_state_params.svh"
module bus_remote_local
  import bus_state_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              renPin,
  input  wire logic              ifcPin,
  input  wire logic              atnPin,
  input  wire logic [7:0]        dataPin,
  input  wire logic              byteStrobe,
  input  wire logic              localKey,
  input  wire logic [7:0]        keysIn,
  input  wire logic [7:0]        statusSummary,
  input  wire logic              pollByteRead,
  output logic [7:0]             keysOut,
  output logic                   devClear,
  output logic                   trigger,
  output logic [7:0]             pollByte,
  output logic                   srqOut,
  output lamps_t                 lamps,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Decode looks at twelve address bits
  if (ADDR_W < 12) begin : gAddrCheck
    $error("ADDR_W too small for register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers (two flops each)
  busbyte_t   pinA_r, pinB_r;
  logic [2:0] ctlA_r, ctlB_r;
  logic [1:0] keyLocA_r, keyLocB_r;
  logic [7:0] keysA_r, keysB_r;
  logic       strobeOld_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinA_r    <= '0;
      pinB_r    <= '0;
      ctlA_r    <= '0;
      ctlB_r    <= '0;
      keyLocA_r <= '0;
      keyLocB_r <= '0;
      keysA_r   <= '0;
      keysB_r   <= '0;
    end else begin
      pinA_r    <= '{atn: atnPin, data: dataPin};
      pinB_r    <= pinA_r;
      ctlA_r    <= {renPin, ifcPin, byteStrobe};
      ctlB_r    <= ctlA_r;
      keyLocA_r <= {localKey, pollByteRead};
      keyLocB_r <= keyLocA_r;
      keysA_r   <= keysIn;
      keysB_r   <= keysA_r;
    end
  end

  // Edge detect on the synchronised strobe; the local key is edge detected below
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeOld_r <= 1'b0;
    end else begin
      strobeOld_r <= ctlB_r[0];
    end
  end

  logic ren, ifc, byteNew, keyLocal, polled, keyLocalOld_r;
  assign ren     = ctlB_r[2];
  assign ifc     = ctlB_r[1];
  assign byteNew = ctlB_r[0] & ~strobeOld_r;
  assign polled  = keyLocB_r[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyLocalOld_r <= 1'b0;
    end else begin
      keyLocalOld_r <= keyLocB_r[1];
    end
  end
  assign keyLocal = keyLocB_r[1] & ~keyLocalOld_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers written by software
  logic [1:0] ctrl_r;
  logic [4:0] myAddr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode of one bus byte under attention
  function automatic logic isCmd(input busbyte_t b, input logic [6:0] c);
    return b.atn && (b.data[6:0] == c);
  endfunction

  function automatic logic isAddr(input busbyte_t b, input logic [1:0] g,
                                  input logic [4:0] a);
    return b.atn && (b.data[6:5] == g) && (b.data[4:0] == a);
  endfunction

  logic cmdMla, cmdMta, cmdUnl, cmdUnt, cmdOta;
  logic cmdGtl, cmdLlo, cmdDcl, cmdSdc, cmdGet, cmdSpe, cmdSpd;

  always_comb begin
    cmdMla = byteNew & isAddr(pinB_r, `GRP_LISTEN, myAddr_r);
    cmdMta = byteNew & isAddr(pinB_r, `GRP_TALK, myAddr_r);
    cmdUnl = byteNew & isAddr(pinB_r, `GRP_LISTEN, `UNL_LOW);
    cmdUnt = byteNew & isAddr(pinB_r, `GRP_TALK, `UNL_LOW);
    cmdOta = byteNew & pinB_r.atn & (pinB_r.data[6:5] == `GRP_TALK)
             & ~cmdMta & ~cmdUnt;
    cmdGtl = byteNew & isCmd(pinB_r, `CMD_GTL);
    cmdLlo = byteNew & isCmd(pinB_r, `CMD_LLO);
    cmdDcl = byteNew & isCmd(pinB_r, `CMD_DCL);
    cmdSdc = byteNew & isCmd(pinB_r, `CMD_SDC);
    cmdGet = byteNew & isCmd(pinB_r, `CMD_GET);
    cmdSpe = byteNew & isCmd(pinB_r, `CMD_SPE);
    cmdSpd = byteNew & isCmd(pinB_r, `CMD_SPD);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Talker and listener state
  logic talk_r, listen_r, spoll_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      talk_r   <= 1'b0;
      listen_r <= 1'b0;
    end else if (ifc) begin
      talk_r   <= 1'b0;
      listen_r <= 1'b0;
    end else begin
      if (cmdMta) talk_r <= 1'b1;
      else if (cmdUnt || cmdOta || cmdMla) talk_r <= 1'b0;
      if (cmdMla) listen_r <= 1'b1;
      else if (cmdUnl || cmdMta) listen_r <= 1'b0;
    end
  end

  // Serial poll mode enable/disable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spoll_r <= 1'b0;
    end else if (ifc || cmdSpd) begin
      spoll_r <= 1'b0;
    end else if (cmdSpe) begin
      spoll_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote and lockout state
  logic remote_r, lockout_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_r <= 1'b0;
    end else if (ifc || !ren || cmdGtl) begin
      remote_r <= 1'b0;
    end else if (cmdMla) begin
      remote_r <= 1'b1;
    end else if (keyLocal && !lockout_r) begin
      remote_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_r <= 1'b0;
    end else if (cmdGtl || !ren) begin
      lockout_r <= 1'b0;
    end else if (cmdLlo) begin
      lockout_r <= 1'b1;
    end
  end

  // Front-panel key gating; power is not routed here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keysOut <= '0;
    end else begin
      keysOut <= (remote_r || lockout_r) ? '0 : keysB_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear and trigger pulses; no settings touched here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      devClear <= 1'b0;
      trigger  <= 1'b0;
    end else begin
      devClear <= cmdDcl || (cmdSdc && listen_r);
      trigger  <= cmdGet && listen_r && ctrl_r[`CTRL_BUSTRIG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service request and poll byte
  logic rqs_r, mssOld_r, mss;
  assign mss = ctrl_r[`CTRL_SRQEN] & (|statusSummary);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rqs_r    <= 1'b0;
      mssOld_r <= 1'b0;
    end else begin
      mssOld_r <= mss;
      if (mss && !mssOld_r) rqs_r <= 1'b1;      // Set beats clear
      else if (!mss || (polled && spoll_r)) rqs_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pollByte <= '0;
      srqOut   <= 1'b0;
      lamps    <= '0;
    end else begin
      pollByte <= {statusSummary[7], rqs_r, statusSummary[5:0]};
      srqOut   <= rqs_r;
      lamps    <= '{remote: remote_r, talk: talk_r,
                    listen: listen_r, service: rqs_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic awHeld_r, wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic        doWrite;
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r     <= 1'b0;
      wHeld_r      <= 1'b0;
      awAddr_r     <= '0;
      wData_r      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r[11:0] == `OFS_CTRL ||
                         awAddr_r[11:0] == `OFS_ADDR) ? `RESP_OKAY
                                                      : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; address outside 0..30 is ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= '0;
      myAddr_r <= `ADDR_DEFAULT;
    end else if (doWrite) begin
      if (awAddr_r[11:0] == `OFS_CTRL) ctrl_r <= wData_r[1:0];
      if (awAddr_r[11:0] == `OFS_ADDR && wData_r[4:0] <= `ADDR_MAX)
        myAddr_r <= wData_r[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, one cycle latency
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      unique case (s_axi_araddr[11:0])
        `OFS_CTRL:   s_axi_rdata <= {30'h0, ctrl_r};
        `OFS_STATUS: s_axi_rdata <= {27'h0, spoll_r, lockout_r, remote_r,
                                     talk_r, listen_r};
        `OFS_STB:    s_axi_rdata <= {24'h0, pollByte};
        `OFS_ADDR:   s_axi_rdata <= {27'h0, myAddr_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- bench/bus_remote_local_sva.sv ----
// Checker for the bus remote/local state logic, bound to its ports.
// Assumes a single ref_clk domain with asynchronous active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module bus_remote_local_sva
  import bus_state_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        renPin,
  input wire logic        ifcPin,
  input wire logic [7:0]  keysOut,
  input wire logic [7:0]  statusSummary,
  input wire logic        pollByteRead,
  input wire logic        devClear,
  input wire logic        trigger,
  input wire logic        srqOut,
  input wire lamps_t      lamps,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Lines held long enough to pass the synchroniser and the state flop
  sequence ifcHeld; ifcPin[*7]; endsequence
  sequence renLow; !renPin[*7]; endsequence
  a_keys_gated:
    assert property (lamps.remote && $past(lamps.remote) |-> keysOut == 8'h00)
      else $error("front panel keys pass while remote");
  a_clear_pulse:
    assert property (devClear |=> !devClear) else $error("clear not a pulse");
  a_trig_pulse:
    assert property (trigger |=> !trigger) else $error("trigger not a pulse");
  a_talk_listen_excl:
    assert property (!(lamps.talk && lamps.listen))
      else $error("talk and listen lamps lit together");
  a_ifc_idles:
    assert property (ifcHeld |-> !lamps.talk && !lamps.listen && !lamps.remote)
      else $error("interface clear left a lamp lit");
  a_ren_local:
    assert property (renLow |-> !lamps.remote)
      else $error("remote lamp lit without remote enable");
  a_service_lamp:
    assert property (lamps.service && !$past(pollByteRead, 3) &&
                     $past(statusSummary) != 8'h00 |=> lamps.service)
      else $error("service lamp dropped without poll or clear");
  a_bresp_legal:
    assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("illegal write response");
  a_rerr_zero:
    assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
      else $error("error read returns data");
endmodule
bind bus_remote_local bus_remote_local_sva bus_remote_local_sva_inst (
  .ref_clk       (ref_clk),
  .rst_n         (rst_n),
  .renPin        (renPin),
  .ifcPin        (ifcPin),
  .keysOut       (keysOut),
  .statusSummary (statusSummary),
  .pollByteRead  (pollByteRead),
  .devClear      (devClear),
  .trigger       (trigger),
  .srqOut        (srqOut),
  .lamps         (lamps),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid)
);
`default_nettype wire

// ---- bench/bus_ctrl_model.sv ----
// Behavioural bus controller driving the device's bus lines.
// Assumes the bench calls its tasks one at a time on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input  wire logic  ref_clk,
  output logic       renPin,
  output logic       ifcPin,
  output logic       atnPin,
  output logic [7:0] dataPin,
  output logic       byteStrobe,
  output logic       pollByteRead
);
  // Lines idle, data lines floating with a pattern
  initial begin
    {renPin, ifcPin, atnPin, byteStrobe, pollByteRead} = 5'h00;
    dataPin = 8'h5a;
  end
  // Attention byte held around the strobe, then released
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk);
    atnPin     <= 1'b1;
    dataPin    <= b;
    byteStrobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    byteStrobe <= 1'b0;
    repeat (2) @(posedge ref_clk);
    atnPin  <= 1'b0;
    dataPin <= ~b;  // No stale value once released
    repeat (6) @(posedge ref_clk);
  endtask
  // Remote enable level
  task automatic ren(input logic v);
    @(posedge ref_clk);
    renPin <= v;
    repeat (8) @(posedge ref_clk);
  endtask
  // Interface clear held for 100 us (20000 cycles)
  task automatic ifc();
    @(posedge ref_clk);
    ifcPin <= 1'b1;
    repeat (20000) @(posedge ref_clk);
    ifcPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // Serial poll: enable, read the byte, disable
  task automatic poll();
    put(8'h18);
    @(posedge ref_clk);
    pollByteRead <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pollByteRead <= 1'b0;
    put(8'h19);
  endtask
endmodule
`default_nettype wire

// ---- bench/bus_remote_local_bench.sv ----
// Self-checking bench for the bus remote/local state logic.
// Assumes the controller model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
`include "bus_state_params.svh"
module bus_remote_local_bench;
  import bus_state_pkg::*;
  logic        ref_clk, rst_n, renPin, ifcPin, atnPin, byteStrobe;
  logic        localKey, pollByteRead, devClear, trigger, srqOut;
  logic [7:0]  dataPin, keysIn, statusSummary, keysOut, pollByte;
  lamps_t      lamps;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_fail, n_checks, nClr, nTrig;
  bus_remote_local bus_remote_local_inst (.*);
  bus_ctrl_model bus_ctrl_model_inst (.*);
  // Clock and pulse counters
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (devClear === 1'b1) nClr++;
    if (trigger === 1'b1) nTrig++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic put(input logic [7:0] b);
    bus_ctrl_model_inst.put(b);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic press();
    @(posedge ref_clk);
    localKey <= 1'b1;
    repeat (3) @(posedge ref_clk);
    localKey <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk(lamps === 4'h0 && keysOut === keysIn, "state after reset");
    rd(`OFS_ADDR);
    chk(rv[4:0] === `ADDR_DEFAULT, "default address");
    rd(`OFS_STATUS);
    chk(rv[4:0] === 5'h00, "status after reset");
    rd(12'h040);
    chk(rs === `RESP_SLVERR, "unmapped read");
    wr(12'h040, 32'h1);
    chk(rs === `RESP_SLVERR, "unmapped write");
    wr(`OFS_ADDR, 32'h1f);
    rd(`OFS_ADDR);
    chk(rv[4:0] === 5'h10, "address 31 taken");
    wr(`OFS_ADDR, 32'h1e);
    rd(`OFS_ADDR);
    chk(rv[4:0] === 5'h1e, "address 30 refused");
    wr(`OFS_ADDR, 32'h10);
  endtask
  task automatic t_remote();
    bus_ctrl_model_inst.ren(1'b1);
    chk(lamps.remote === 1'b0, "remote on enable alone");
    put(8'h30);
    chk(lamps.remote && lamps.listen, "remote or listen");
    chk(keysOut === 8'h00, "keys pass in remote");
    put(8'h50);
    chk(lamps.talk && !lamps.listen, "talk in remote");
    put(8'h5f);
    chk(lamps.talk === 1'b0, "untalk");
    press();
    chk(!lamps.remote && keysOut === keysIn, "local key");
    put(8'h30);
    put({1'b0, `CMD_LLO});
    press();
    chk(lamps.remote && keysOut === 8'h00, "key under lockout");
    put({1'b0, `CMD_GTL});
    chk(!lamps.remote && keysOut === keysIn, "go to local");
    put(8'h30);
    press();
    chk(lamps.remote === 1'b0, "lockout kept");
  endtask
  task automatic t_clear();
    int c0, g0;
    c0 = nClr;
    g0 = nTrig;
    put(8'h3f);
    chk(lamps.listen === 1'b0, "unlisten");
    put({1'b0, `CMD_SDC});
    chk(nClr == c0, "selective clear unaddressed");
    put({1'b0, `CMD_DCL});
    chk(nClr == c0 + 1, "universal clear");
    put(8'h30);
    put({1'b0, `CMD_SDC});
    chk(nClr == c0 + 2, "selective clear addressed");
    put({1'b0, `CMD_GET});
    chk(nTrig == g0, "trigger source not bus");
    wr(`OFS_CTRL, 32'h1);
    put({1'b0, `CMD_GET});
    chk(nTrig == g0 + 1, "bus trigger");
  endtask
  task automatic t_poll();
    statusSummary <= 8'h10;
    wr(`OFS_CTRL, 32'h2);
    repeat (8) @(posedge ref_clk);
    chk(srqOut && lamps.service && pollByte === 8'h50, "service request");
    rd(`OFS_STB);
    chk(rv[7:0] === 8'h50, "status byte read");
    bus_ctrl_model_inst.poll();
    chk(!srqOut && pollByte === 8'h10, "poll clears request");
    put(8'h50);
    chk(lamps.talk === 1'b1, "not addressed to talk");
    bus_ctrl_model_inst.ifc();
    chk(lamps === 4'h0, "interface clear");
    rd(`OFS_CTRL);
    chk(rv[1:0] === 2'b10, "settings kept");
    put(8'h30);
    chk(lamps.remote === 1'b1, "no remote after clear");
    bus_ctrl_model_inst.ren(1'b0);
    chk(lamps.remote === 1'b0, "remote kept without enable");
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    {rst_n, localKey, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    keysIn        = 8'ha5;
    statusSummary = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_regs();
    t_remote();
    t_clear();
    t_poll();
    results();
  end
endmodule
`default_nettype wire
